//--- hdl/pto_pkg.sv
// Purpose: shared constants for the pulse-width and tone output block
// Assumes: 25 MHz system clock, 32-bit AXI4-Lite register access
// Notes:   all offsets are byte addresses of aligned words
package pto_pkg;
  // clock and timing
  localparam int CLK_HZ          = 25_000_000;
  localparam int PWM_STEP_NS     = 1000;                        // one duty step is 1 us
  localparam int PWM_STEP_CYC    = (CLK_HZ / 1_000_000) * PWM_STEP_NS / 1000;
  localparam int TONE_MAX_HZ     = 4_000_000;                   // fastest tone frequency
  localparam int TONE_MIN_CYC    = (CLK_HZ + TONE_MAX_HZ - 1) / TONE_MAX_HZ;
  localparam int PWM_MAX_HZ      = 1_000_000;                   // fastest pwm frequency
  localparam int PWM_MIN_STEPS   = 1_000_000 / PWM_MAX_HZ;      // shortest period in steps

  // register byte offsets
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_PWM_PERIOD = 8'h04;
  localparam logic [7:0] REG_PWM_DUTY   = 8'h08;
  localparam logic [7:0] REG_TONE_PER   = 8'h0c;
  localparam logic [7:0] REG_PIN_FUNC   = 8'h10;
  localparam logic [7:0] REG_GPIO_OUT   = 8'h14;
  localparam logic [7:0] REG_STATUS     = 8'h18;
  localparam logic [7:0] REG_TONE_DUTY0 = 8'h40;               // one word per pin after this

  // field positions
  localparam int CTRL_PWM_EN_BIT  = 0;
  localparam int CTRL_TONE_EN_BIT = 1;

  // reset values
  localparam logic [15:0] PWM_PERIOD_RST = 16'h03e8;            // 1000 us, 1 kHz
  localparam logic [15:0] PWM_DUTY_RST   = 16'h0000;
  localparam logic [23:0] TONE_PER_RST   = 24'h000000;          // static
  localparam logic [8:0]  TONE_DUTY_RST  = 9'h080;              // half of 256, equal mark-space
  localparam logic [8:0]  TONE_DUTY_FULL = 9'h100;

  // pin function select, two bits per pin
  typedef enum logic [1:0] {
    PTO_FN_GPIO = 2'b00,
    PTO_FN_PWM  = 2'b01,
    PTO_FN_TONE = 2'b11,
    PTO_FN_OFF  = 2'b10
  } pto_fn_e;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- hdl/pto_top.sv
// Purpose: pulse-width and fixed-frequency outputs on the signal_io_pin group
// Assumes: single 25 MHz clock, synchronous active-low reset, AXI4-Lite slave
// Notes:   period and duty settings are shadowed and take effect at period ends
`timescale 1ns/1ps
`default_nettype none
module pto_top
  import pto_pkg::*;
#(
  parameter int PINS = 16
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [PINS-1:0]        signal_io_pin_out,
  output logic [PINS-1:0]        signal_io_pin_oe
);

  // byte-enable merge, used for every writable word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        old[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return old;
  endfunction

  // tone high while phase/period < duty/256, without a divider
  function automatic logic tone_high(input logic [23:0] ph, input logic [23:0] per,
                                     input logic [8:0] duty);
    logic [32:0] lhs;
    logic [32:0] rhs;
    lhs = {1'b0, ph, 8'h00};
    rhs = 33'(per) * 33'(duty);
    return lhs < rhs;
  endfunction

  // software-visible registers
  logic [1:0]      ctrl;
  logic [15:0]     pwm_period;
  logic [15:0]     pwm_duty;
  logic [23:0]     tone_per;
  logic [31:0]     pin_func;
  logic [PINS-1:0] gpio_out;
  logic [8:0]      tone_duty [PINS];

  // axi write side: address and data held until both are present
  logic       aw_full;
  logic       w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  wire aw_take  = s_axi_awvalid & s_axi_awready;
  wire w_take   = s_axi_wvalid & s_axi_wready;
  wire wr_do    = aw_full & w_full & ~s_axi_bvalid;
  wire next_aw_full = (aw_full | aw_take) & ~wr_do;
  wire next_w_full  = (w_full | w_take) & ~wr_do;
  wire [5:0] wr_word = aw_addr[7:2];
  wire wr_algn  = (aw_addr[1:0] == 2'b00); // unaligned words count as unmapped
  wire wr_is_duty = wr_algn && (aw_addr >= REG_TONE_DUTY0) &&
                    (aw_addr < REG_TONE_DUTY0 + 8'(PINS * 4));
  wire [3:0] wr_pin = 4'(wr_word - REG_TONE_DUTY0[7:2]);
  wire wr_hit = wr_is_duty || (wr_algn && (wr_word <= REG_GPIO_OUT[7:2]));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      aw_full       <= next_aw_full;
      w_full        <= next_w_full;
      s_axi_awready <= ~next_aw_full;
      s_axi_wready  <= ~next_w_full;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes; status is read-only so it falls to slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl       <= 2'b00;
      pwm_period <= PWM_PERIOD_RST;
      pwm_duty   <= PWM_DUTY_RST;
      tone_per   <= TONE_PER_RST;
      pin_func   <= 32'h00000000;
      gpio_out   <= '0;
      for (int i = 0; i < PINS; i++) begin
        tone_duty[i] <= TONE_DUTY_RST;
      end
    end else if (wr_do) begin
      case (aw_addr)
        REG_CTRL:       ctrl       <= 2'(merge(32'(ctrl), w_data, w_strb));
        REG_PWM_PERIOD: pwm_period <= 16'(merge(32'(pwm_period), w_data, w_strb));
        REG_PWM_DUTY:   pwm_duty   <= 16'(merge(32'(pwm_duty), w_data, w_strb));
        REG_TONE_PER:   tone_per   <= 24'(merge(32'(tone_per), w_data, w_strb));
        REG_PIN_FUNC:   pin_func   <= merge(pin_func, w_data, w_strb);
        REG_GPIO_OUT:   gpio_out   <= PINS'(merge(32'(gpio_out), w_data, w_strb));
        default: begin
          if (wr_is_duty) begin
            tone_duty[wr_pin] <= 9'(merge(32'(tone_duty[wr_pin]), w_data, w_strb));
          end
        end
      endcase
    end
  end

  // axi read side, one-cycle registered answer
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rd_is_duty = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr >= REG_TONE_DUTY0) &&
                    (s_axi_araddr < REG_TONE_DUTY0 + 8'(PINS * 4));
  wire [3:0] rd_pin = 4'(s_axi_araddr[7:2] - REG_TONE_DUTY0[7:2]);
  logic [31:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h00000000;
    case (s_axi_araddr)
      REG_CTRL:       rd_val = 32'(ctrl);
      REG_PWM_PERIOD: rd_val = 32'(pwm_period);
      REG_PWM_DUTY:   rd_val = 32'(pwm_duty);
      REG_TONE_PER:   rd_val = 32'(tone_per);
      REG_PIN_FUNC:   rd_val = pin_func;
      REG_GPIO_OUT:   rd_val = 32'(gpio_out);
      REG_STATUS:     rd_val = 32'(signal_io_pin_out);  // live pin levels
      default: begin
        if (rd_is_duty) begin
          rd_val = 32'(tone_duty[rd_pin]);
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~(s_axi_rvalid & ~s_axi_rready) & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // 1 us step enable from the system clock
  logic [4:0] step_div;
  wire step_tick = (step_div == 5'(PWM_STEP_CYC - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn || step_tick) begin
      step_div <= 5'h00;
    end else begin
      step_div <= step_div + 5'h01;
    end
  end

  // pwm: phase counts whole microseconds, so steps per period = period in us
  logic [15:0] pwm_ph;
  logic [15:0] pwm_per_sh;
  logic [15:0] pwm_duty_sh;
  logic        pwm_level;
  wire [15:0] pwm_per_eff = (pwm_period < 16'(PWM_MIN_STEPS)) ? 16'(PWM_MIN_STEPS)
                                                                : pwm_period;
  wire pwm_wrap = step_tick && (pwm_ph >= pwm_per_sh - 16'h0001);
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl[CTRL_PWM_EN_BIT]) begin
      pwm_ph      <= 16'h0000;
      pwm_per_sh  <= pwm_per_eff;
      pwm_duty_sh <= pwm_duty;
    end else if (pwm_wrap) begin
      pwm_ph      <= 16'h0000;
      pwm_per_sh  <= pwm_per_eff;
      pwm_duty_sh <= pwm_duty;
    end else if (step_tick) begin
      pwm_ph <= pwm_ph + 16'h0001;
    end
  end
  // duty 0 never true, duty >= period always true: no runt pulses
  assign pwm_level = ctrl[CTRL_PWM_EN_BIT] && (pwm_ph < pwm_duty_sh);

  // tone: one shared period in clock cycles, zero means static low
  logic [23:0] tone_ph;
  logic [23:0] tone_per_sh;
  logic [8:0]  tone_duty_sh [PINS];
  wire [23:0] tone_per_eff = (tone_per != 24'h000000 && tone_per < 24'(TONE_MIN_CYC)) ?
                             24'(TONE_MIN_CYC) : tone_per;
  wire tone_run  = ctrl[CTRL_TONE_EN_BIT] && (tone_per_sh != 24'h000000);
  wire tone_wrap = !tone_run || (tone_ph >= tone_per_sh - 24'h000001);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tone_ph     <= 24'h000000;
      tone_per_sh <= TONE_PER_RST;
      for (int i = 0; i < PINS; i++) begin
        tone_duty_sh[i] <= TONE_DUTY_RST;
      end
    end else if (tone_wrap) begin
      tone_ph     <= 24'h000000;
      tone_per_sh <= tone_per_eff;
      for (int i = 0; i < PINS; i++) begin
        tone_duty_sh[i] <= tone_duty[i];
      end
    end else begin
      tone_ph <= tone_ph + 24'h000001;
    end
  end

  // per-pin function mux; every pin may carry the same pwm at once
  logic [PINS-1:0] next_pin;
  logic [PINS-1:0] next_oe;
  always_comb begin
    for (int i = 0; i < PINS; i++) begin
      case (pto_fn_e'(pin_func[2*i +: 2]))
        PTO_FN_GPIO: next_pin[i] = gpio_out[i];
        PTO_FN_PWM:  next_pin[i] = pwm_level;
        PTO_FN_TONE: next_pin[i] = tone_run && tone_high(tone_ph, tone_per_sh,
                                                         tone_duty_sh[i]);
        default:     next_pin[i] = 1'b0;
      endcase
      next_oe[i] = (pto_fn_e'(pin_func[2*i +: 2]) != PTO_FN_OFF);
    end
  end

  // registered pins keep decode hazards off the pads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      signal_io_pin_out <= '0;
      signal_io_pin_oe  <= '0;
    end else begin
      signal_io_pin_out <= next_pin;
      signal_io_pin_oe  <= next_oe;
    end
  end

endmodule
`default_nettype wire

//--- tb/pto_load_model.sv
// Purpose: loads on the signal_io_pin group
// Assumes: no pull resistor on the pins
// Notes:   an undriven pin flips every cycle so a stale level never looks valid
`timescale 1ns/1ps
`default_nettype none
module pto_load_model #(
  parameter int PINS = 16
) (
  input  wire logic            aclk,
  input  wire logic [PINS-1:0] out,
  input  wire logic [PINS-1:0] oe,
  output logic      [PINS-1:0] lvl
);
  logic [PINS-1:0] last = '0;
  // level seen by the load, floating pins inverted
  always_comb lvl = (oe & out) | (~oe & ~last);
  // plain always, since the start value comes from the declaration
  always @(posedge aclk) last <= lvl;
endmodule
`default_nettype wire

//--- tb/pto_checker.sv
// Purpose: bus handshake checks for the pulse-width and tone block
// Assumes: one clock, synchronous active-low reset
// Notes:   pin waveforms are judged by the bench counts
`timescale 1ns/1ps
`default_nettype none
module pto_checker
  import pto_pkg::*;
#(
  parameter int PINS = 16
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // write steps: both halves taken, one hold cycle, then answer
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  property p_wr_lat;
    s_wr_taken |=> s_wr_answer;
  endproperty
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rdata, s_axi_rresp});
  endproperty
  property p_ar_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_aw_busy;
    s_wr_taken |=> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late or early");
  a_rd_lat: assert property (p_rd_lat) else $error("read answer not next cycle");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped early");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped early");
  a_ar_busy: assert property (p_ar_busy) else $error("read address taken while busy");
  a_aw_busy: assert property (p_aw_busy) else $error("write channel open while holding");
  a_b_done: assert property (p_b_done) else $error("write channel not reopened");
  a_r_done: assert property (p_r_done) else $error("read channel not reopened");
endmodule
bind pto_top pto_checker #(.PINS(PINS)) i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

//--- tb/test_pto_top.sv
// Purpose: register and waveform tests of the pulse-width and tone block
// Assumes: 25 MHz clock, windows are whole periods so phase drops out
// Notes:   high-time counts are taken on the load side at the falling edge
`timescale 1ns/1ps
`default_nettype none
module test_pto_top;
  import pto_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdt, v;
  logic        awv = 1'b0, wv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic        awr, wr_rdy, bv, arr, rv;
  logic [1:0]  bresp, rresp, r;
  logic [15:0] pout, poe, plvl;
  int          err_total = 0, num_checks = 0, cyc = 0;
  // period us, duty us, high clocks in 200
  int pw[6][3] = '{'{4,1,50}, '{2,0,0}, '{2,1,100}, '{2,2,200}, '{1,0,0}, '{1,1,200}};
  // tone period, pin, high clocks in 210
  int tn[6][3] = '{'{10,0,105}, '{10,1,210}, '{10,2,0}, '{10,3,63}, '{5,0,120}, '{0,0,0}};
  pto_top #(.PINS(16)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brd),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrd),
    .signal_io_pin_out(pout), .signal_io_pin_oe(poe));
  pto_load_model #(.PINS(16)) i_load (.aclk(aclk), .out(pout), .oe(poe), .lvl(plvl));
  always #20 aclk = ~aclk;
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // hang guard, the full run needs about 5700 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  // each half released when taken; response awaited with bready held
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    brd <= 1'b0;
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rrd <= 1'b0;
    d = rdt;
    rr = rresp;
  endtask
  task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    rd(a, v, r);
    chk(n, v, e);
    chk("rresp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  // count load-side high clocks of one pin
  task meas(input int i, input int n, output logic [31:0] h);
    h = 32'h0;
    repeat (n) begin
      @(negedge aclk);
      h = h + {31'h0, plvl[i]};
    end
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("pin_out", {16'h0, pout}, 32'h0);
    chk("pin_oe", {16'h0, poe}, 32'h0);
    rchk("ctrl", REG_CTRL, 32'h0);
    rchk("pwm_period", REG_PWM_PERIOD, 32'h3e8);
    rchk("pwm_duty", REG_PWM_DUTY, 32'h0);
    rchk("tone_per", REG_TONE_PER, 32'h0);
    rchk("tone_duty", REG_TONE_DUTY0, 32'h80);
    rd(8'h1c, v, r);
    chk("unmapped_data", v, 32'h0);
    chk("unmapped_resp", {30'h0, r}, {30'h0, RESP_SLVERR});
    wr(REG_STATUS, 32'h1, RESP_SLVERR);
    wr(REG_PIN_FUNC, 32'h0);
    wr(REG_GPIO_OUT, 32'ha5c3);
    repeat (3) @(posedge aclk);
    rchk("status", REG_STATUS, 32'ha5c3);
    wr(REG_PIN_FUNC, 32'haaaa_aaaa);
    repeat (3) @(negedge aclk);
    chk("oe_off", {16'h0, poe}, 32'h0);
    $display("test registers done");
    wr(REG_PIN_FUNC, 32'h5555_5555);
    // short period first, else the 1000 us reset period holds the shadows
    wr(REG_PWM_PERIOD, 32'h4);
    wr(REG_CTRL, 32'h1);
    repeat (3) @(negedge aclk);
    chk("oe_pwm", {16'h0, poe}, 32'hffff);
    // duty changes while running land at the next period end
    foreach (pw[k]) begin
      wr(REG_PWM_PERIOD, pw[k][0]);
      wr(REG_PWM_DUTY, pw[k][1]);
      repeat (250) @(posedge aclk);
      for (int j = 0; j < 16; j += 15) begin
        meas(j, 200, v);
        chk("pwm_high", v, pw[k][2]);
      end
    end
    $display("test pwm done");
    wr(REG_CTRL, 32'h2);
    wr(REG_PIN_FUNC, 32'hffff_ffff);
    wr(REG_TONE_DUTY0 + 8'h04, 32'h100);
    wr(REG_TONE_DUTY0 + 8'h08, 32'h0);
    wr(REG_TONE_DUTY0 + 8'h0c, 32'h40);
    foreach (tn[k]) begin
      wr(REG_TONE_PER, tn[k][0]);
      repeat (60) @(posedge aclk);
      meas(tn[k][1], 210, v);
      chk("tone_high", v, tn[k][2]);
    end
    $display("test tone done");
    give_verdict();
  end
endmodule
`default_nettype wire
